// *** awpc_ctrl.sv ***
// Array write protection controller: registers, latch and write gating
`timescale 1ns/10ps
module awpc_ctrl #(
  parameter int ADDR_W = awpc_pkg::ADDR_W_DEF
) (
  // Clock and reset
  input  wire logic              clk,
  input  wire logic              rst,
  // Pins from outside the clock domain
  input  wire logic              chipSelectN,
  input  wire logic              writeProtectN,
  input  wire logic [2:0]        hwBlockProtectPins,
  input  wire logic              hwRangeEndSelect,
  // Array engine state
  input  wire logic              busy,
  // Decoded instruction requests
  input  wire awpc_pkg::awpc_req_s  req,
  // Answers
  output awpc_pkg::awpc_resp_s      resp
);

  // ****************************************
  // Pin synchronisers
  // ****************************************
  logic [5:0] pinMeta;   // First stage, read only by second
  logic [5:0] pinSync2;  // Second stage
  logic [5:0] pinSync3;  // Third stage
  logic [5:0] pinClean;  // Accepted pin levels
  logic       csHigh;    // Chip select deasserted
  logic       wpLow;     // Write protect pin low
  logic [2:0] hwCode;    // Hardware block protect code
  logic       hwBottom;  // Hardware range end select

  // Three stages; chip select and write protect idle high, other pins pulled low
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      pinMeta  <= 6'h03;
      pinSync2 <= 6'h03;
      pinSync3 <= 6'h03;
    end else begin
      pinMeta  <= {hwRangeEndSelect, hwBlockProtectPins, writeProtectN, chipSelectN};
      pinSync2 <= pinMeta;
      pinSync3 <= pinSync2;
    end
  end

  // A change counts once second and third stages agree, per bit
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      pinClean <= 6'h03;
    end else begin
      pinClean <= (pinSync2 & ~(pinSync2 ^ pinSync3)) | (pinClean & (pinSync2 ^ pinSync3));
    end
  end

  assign csHigh   = pinClean[0];
  assign wpLow    = ~pinClean[1];
  assign hwCode   = pinClean[4:2];
  assign hwBottom = pinClean[5];

  // ****************************************
  // Frame tracking
  // ****************************************
  typedef enum logic [1:0] {
    FR_IDLE   = 2'b01, // Chip select high
    FR_ACTIVE = 2'b10  // Chip select low
  } awpc_frame_e;

  awpc_frame_e frameState; // Current frame state
  awpc_frame_e next_frameState;
  logic        frameEnd;   // Chip select just returned high

  // Frame end is the accepted rising edge of chip select
  always_comb begin
    next_frameState = frameState;
    frameEnd        = 1'b0;
    case (frameState)
      FR_IDLE: begin
        if (!csHigh) begin
          next_frameState = FR_ACTIVE;
        end
      end
      FR_ACTIVE: begin
        if (csHigh) begin
          next_frameState = FR_IDLE;
          frameEnd        = 1'b1;
        end
      end
      default: begin
        next_frameState = FR_IDLE;
      end
    endcase
  end

  // Frame state register
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      frameState <= FR_IDLE;
    end else begin
      frameState <= next_frameState;
    end
  end

  // ****************************************
  // Registers and request decode
  // ****************************************
  logic [7:0] statusReg;   // Protection status, latch bit unused here
  logic [7:0] configReg;   // Protection config one
  logic       writeLatch;  // Write enable latch
  logic       regWrInFrame; // A register write happened this frame
  logic       readyFlag;   // Registered ready state
  logic [1:0] wrMode;      // Write enable mode
  logic       lockOn;      // Protection lock
  logic       isRegWr;     // Register write request
  logic       isArrWr;     // Array write request
  logic       isRead;      // Register read request
  logic       regWrOk;     // Register write permitted
  logic       arrWrOk;     // Array write permitted
  logic       swHit;       // Address in software range
  logic       hwHit;       // Address in hardware range
  logic       protHit;     // Address in any protected range
  logic [31:0] identWord;  // Fixed identification value

  assign wrMode  = configReg[awpc_pkg::CR_MODE_LSB +: 2];
  assign lockOn  = configReg[awpc_pkg::CR_LOCK_POS];
  assign isRegWr = req.valid && (req.kind == awpc_pkg::REQ_REG_WRITE);
  assign isArrWr = req.valid && (req.kind == awpc_pkg::REQ_ARRAY_WRITE);
  assign isRead  = req.valid && (req.kind == awpc_pkg::REQ_REG_READ);
  assign identWord = {awpc_pkg::ID_MAKER, awpc_pkg::ID_IFACE, awpc_pkg::ID_VOLT,
                      awpc_pkg::ID_TEMP, awpc_pkg::ID_DENSITY, awpc_pkg::ID_FREQ};

  // Register writes need the latch, and are blocked by an enabled low pin
  assign regWrOk = writeLatch &&
                   !(statusReg[awpc_pkg::SR_PIN_EN_POS] && wpLow);

  // ****************************************
  // Protected range lookup
  // ****************************************
  awpc_range_decode #(.ADDR_W(ADDR_W)) swRange (
    .code       (statusReg[awpc_pkg::SR_CODE_LSB +: 3]),
    .fromBottom (statusReg[awpc_pkg::SR_RANGE_POS]),
    .addr       (req.addr[ADDR_W-1:0]),
    .hit        (swHit)
  );

  awpc_range_decode #(.ADDR_W(ADDR_W)) hwRange (
    .code       (hwCode),
    .fromBottom (hwBottom),
    .addr       (req.addr[ADDR_W-1:0]),
    .hit        (hwHit)
  );

  // Union of both ranges; pins never lift software protection
  assign protHit = swHit | hwHit;
  // Mode 01 bypasses the latch; mode 11 is never set by the host
  assign arrWrOk = !protHit &&
                   (writeLatch || (wrMode == awpc_pkg::MODE_SRAM));

  // ****************************************
  // Status register
  // ****************************************
  // Locked bits keep their value without refusing the rest of the write
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      statusReg <= awpc_pkg::SR_RESET;
    end else if (isRegWr && regWrOk && (req.regAddr == awpc_pkg::OFS_STATUS)) begin
      if (lockOn) begin
        statusReg <= (req.data & awpc_pkg::SR_WR_MSK & ~awpc_pkg::SR_LOCKED_MSK) |
                     (statusReg & awpc_pkg::SR_LOCKED_MSK);
      end else begin
        statusReg <= req.data & awpc_pkg::SR_WR_MSK;
      end
    end
  end

  // ****************************************
  // Config register one
  // ****************************************
  // Reserved bits 4:3 are never stored, so they read zero
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      configReg <= awpc_pkg::CR_RESET;
    end else if (isRegWr && regWrOk && (req.regAddr == awpc_pkg::OFS_CONFIG1)) begin
      configReg <= req.data & awpc_pkg::CR_WR_MSK;
    end
  end

  // ****************************************
  // Write enable latch
  // ****************************************
  // Remembers a register write so the latch drops at deselect in any mode
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      regWrInFrame <= 1'b0;
    end else if (isRegWr && regWrOk) begin
      regWrInFrame <= 1'b1;
    end else if (frameEnd) begin
      regWrInFrame <= 1'b0;
    end
  end

  // Set wins over any clear arriving in the same cycle
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      writeLatch <= 1'b0;
    end else if (req.valid && (req.kind == awpc_pkg::REQ_SET_LATCH)) begin
      writeLatch <= 1'b1;
    end else if (req.valid && (req.kind == awpc_pkg::REQ_CLR_LATCH)) begin
      writeLatch <= 1'b0;
    end else if (frameEnd && (regWrInFrame || (isRegWr && regWrOk) ||
                              (wrMode != awpc_pkg::MODE_B2B))) begin
      writeLatch <= 1'b0;
    end
  end

  // ****************************************
  // Ready flag
  // ****************************************
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      readyFlag <= 1'b1;
    end else begin
      readyFlag <= ~busy;
    end
  end

  // ****************************************
  // Answer path
  // ****************************************
  // One cycle after every request; latch commands answer ok
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      resp <= '0;
    end else begin
      resp.valid <= req.valid;
      resp.ok    <= 1'b0;
      resp.data  <= 32'h0000_0000;
      if (isRegWr) begin
        resp.ok <= regWrOk && ((req.regAddr == awpc_pkg::OFS_STATUS) ||
                               (req.regAddr == awpc_pkg::OFS_CONFIG1));
      end else if (isArrWr) begin
        resp.ok <= arrWrOk;
      end else if (isRead) begin
        resp.ok <= 1'b1;
        case (req.regAddr)
          awpc_pkg::OFS_STATUS: begin
            // Latch shown in its own read-only bit
            resp.data <= {24'h00_0000, statusReg[7:2], writeLatch, statusReg[0]};
          end
          awpc_pkg::OFS_CONFIG1: begin
            resp.data <= {24'h00_0000, configReg};
          end
          awpc_pkg::OFS_FLAGS: begin
            resp.data <= {24'h00_0000, readyFlag, 7'h00};
          end
          awpc_pkg::OFS_IDENT: begin
            resp.data <= identWord;
          end
          default: begin
            // Unmapped offset reads zero and is flagged
            resp.ok <= 1'b0;
          end
        endcase
      end else if (req.valid) begin
        resp.ok <= 1'b1;
      end
    end
  end

  // ****************************************
  // Assertions
  // ****************************************
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);

  AST_LATCH_NORMAL_CLEAR: assert property (
    frameEnd && (wrMode == awpc_pkg::MODE_NORMAL) && !req.valid |=> !writeLatch)
    else $error("latch survived deselect in normal mode");

  AST_LATCH_B2B_HOLD: assert property (
    frameEnd && writeLatch && (wrMode == awpc_pkg::MODE_B2B) && !regWrInFrame &&
    !req.valid |=> writeLatch)
    else $error("latch dropped at deselect in back-to-back mode");

  AST_REG_NEEDS_LATCH: assert property (
    isRegWr && !writeLatch |=> resp.valid && !resp.ok && $stable(statusReg))
    else $error("register write accepted without latch");

  AST_PIN_BLOCKS_REG: assert property (
    isRegWr && statusReg[7] && wpLow |=> !resp.ok)
    else $error("register write accepted under low protect pin");

  AST_PROT_REFUSED: assert property (
    isArrWr && protHit |=> resp.valid && !resp.ok)
    else $error("array write granted inside protected range");

  AST_SRAM_GRANT: assert property (
    isArrWr && !protHit && (wrMode == awpc_pkg::MODE_SRAM) |=> resp.ok)
    else $error("array write refused in latch-free mode");

  AST_LOCK_KEEPS: assert property (
    isRegWr && lockOn && (req.regAddr == awpc_pkg::OFS_STATUS)
    |=> statusReg[5:2] == $past(statusReg[5:2]))
    else $error("locked protection bits changed");

  AST_FLAGS_READ: assert property (
    isRead && (req.regAddr == awpc_pkg::OFS_FLAGS)
    |=> resp.data == {24'h00_0000, ~$past(busy, 2), 7'h00})
    else $error("flags read mismatch");

  AST_ID_READ: assert property (
    isRead && (req.regAddr == awpc_pkg::OFS_IDENT) |=> resp.data == {awpc_pkg::ID_MAKER,
    awpc_pkg::ID_IFACE, awpc_pkg::ID_VOLT, awpc_pkg::ID_TEMP, awpc_pkg::ID_DENSITY,
    awpc_pkg::ID_FREQ})
    else $error("identification read mismatch");

  AST_HW_UNION: assert property (
    isArrWr && hwHit ##1 1'b1 |-> !resp.ok)
    else $error("hardware range ignored");

  COV_ARRAY_GRANT: cover property (isArrWr && writeLatch ##1 resp.ok);
  COV_PIN_REFUSE: cover property (isRegWr && writeLatch && statusReg[7] && wpLow);
  COV_LOCKED_WRITE: cover property (isRegWr && regWrOk && lockOn);
  COV_B2B_FRAME: cover property (frameEnd && writeLatch && (wrMode == awpc_pkg::MODE_B2B));

endmodule

// *** awpc_host_model.sv ***
// Host controller model: frames chip select and issues requests
`timescale 1ns/10ps
module awpc_host_model (
  // Clock
  input  wire logic                 clk,
  // Answers from the device
  input  wire awpc_pkg::awpc_resp_s resp,
  // Requests and chip select
  output awpc_pkg::awpc_req_s       req,
  output logic                      chipSelectN
);
  localparam int LINK_CYC = 8; // One 800 ns link period in clocks

  // Idle bus and deselected device at start
  initial begin
    req         = '0;
    chipSelectN = 1'b1;
  end

  // One request held for one edge; answer taken at the next edge
  task automatic request(input awpc_pkg::awpc_kind_e k, input logic [7:0] ra,
                         input logic [7:0] d, input logic [23:0] a,
                         output awpc_pkg::awpc_resp_s r);
    @(posedge clk);
    #1;
    req <= '{valid: 1'b1, kind: k, regAddr: ra, data: d, addr: a};
    @(posedge clk);
    #1;
    r = resp;
    // Released address and data fields show the inverse; kind keeps its stale value
    req <= '{valid: 1'b0, kind: k, regAddr: ~ra, data: ~d, addr: ~a};
  endtask

  // Select the device, long enough for its synchroniser
  task automatic frameOpen();
    @(posedge clk);
    #1;
    chipSelectN = 1'b0;
    repeat (LINK_CYC) @(posedge clk);
  endtask

  // Deselect; the device sees the frame end a few clocks later
  task automatic frameClose();
    @(posedge clk);
    #1;
    chipSelectN = 1'b1;
    repeat (LINK_CYC) @(posedge clk);
  endtask
endmodule

// *** awpc_pkg.sv ***
// Package of constants and carrier types for the array write protection controller
package awpc_pkg;

  // ****************************************
  // Register offsets
  // ****************************************
  localparam logic [7:0] OFS_STATUS  = 8'h00; // Protection status register
  localparam logic [7:0] OFS_CONFIG1 = 8'h02; // Protection config register
  localparam logic [7:0] OFS_FLAGS   = 8'h0a; // Ready flags register
  localparam logic [7:0] OFS_IDENT   = 8'h30; // Identification word

  // ****************************************
  // Status register fields
  // ****************************************
  localparam int SR_PIN_EN_POS  = 7; // Pin-based protection enable
  localparam int SR_RANGE_POS   = 5; // Range end select bit
  localparam int SR_CODE_LSB    = 2; // Block protect code, bits 4:2
  localparam int SR_LATCH_POS   = 1; // Write enable latch, read only
  localparam logic [7:0] SR_RESET      = 8'h00; // All fields clear
  localparam logic [7:0] SR_LOCKED_MSK = 8'h3c; // Bits frozen by the lock
  localparam logic [7:0] SR_WR_MSK     = 8'hfd; // Software-writable bits

  // ****************************************
  // Config register one fields
  // ****************************************
  localparam int CR_LOCK_POS  = 2; // Protection lock bit
  localparam int CR_MODE_LSB  = 0; // Write enable mode, bits 1:0
  localparam logic [7:0] CR_RESET  = 8'h60; // Drive select 011, rest clear
  localparam logic [7:0] CR_WR_MSK = 8'he7; // Bits 4:3 read as zero

  // ****************************************
  // Flags register fields
  // ****************************************
  localparam int FL_READY_POS = 7; // Ready flag, 1 means ready

  // ****************************************
  // Identification fields, values arbitrary
  // ****************************************
  localparam logic [7:0] ID_MAKER   = 8'h3c; // Arbitrary maker code
  localparam logic [3:0] ID_IFACE   = 4'h2;  // Interface type
  localparam logic [3:0] ID_VOLT    = 4'h1;  // Voltage
  localparam logic [3:0] ID_TEMP    = 4'h2;  // Temperature grade
  localparam logic [3:0] ID_DENSITY = 4'h1;  // Density
  localparam logic [7:0] ID_FREQ    = 8'h01; // Frequency grade

  // ****************************************
  // Write enable modes and geometry
  // ****************************************
  localparam logic [1:0] MODE_NORMAL = 2'h0; // Latch clears at frame end
  localparam logic [1:0] MODE_SRAM   = 2'h1; // Latch ignored for array
  localparam logic [1:0] MODE_B2B    = 2'h2; // Latch held until disable or end of a frame with a granted reg write
  localparam int FRACTION_SHIFT = 7; // Smallest region is 1/64
  localparam int ADDR_W_DEF     = 23; // Byte address width of array

  // ****************************************
  // Request kinds and carriers
  // ****************************************
  typedef enum logic [2:0] {
    REQ_SET_LATCH   = 3'h0, // Write enable instruction
    REQ_CLR_LATCH   = 3'h1, // Write disable instruction
    REQ_REG_WRITE   = 3'h2, // Register write
    REQ_ARRAY_WRITE = 3'h3, // Array write check
    REQ_REG_READ    = 3'h4  // Register read
  } awpc_kind_e;

  typedef struct packed {
    logic       valid;   // Request present this cycle
    awpc_kind_e kind;    // What is asked
    logic [7:0] regAddr; // Register offset
    logic [7:0] data;    // Register write data
    logic [23:0] addr;   // Array byte address
  } awpc_req_s;

  typedef struct packed {
    logic        valid; // One-cycle answer strobe
    logic        ok;    // Granted or mapped
    logic [31:0] data;  // Read data
  } awpc_resp_s;

endpackage

// *** awpc_range_decode.sv ***
// Block protect code decoder: tells whether an address lies in the protected range
`timescale 1ns/10ps
module awpc_range_decode #(
  parameter int ADDR_W = awpc_pkg::ADDR_W_DEF
) (
  // Protection setting
  input  wire logic [2:0]        code,
  input  wire logic              fromBottom,
  // Address to test
  input  wire logic [ADDR_W-1:0] addr,
  // Result
  output logic                   hit
);

  // ****************************************
  // Region decode
  // ****************************************
  logic [ADDR_W-1:0] lowMask; // Bits below the region boundary
  int                lowBits; // Log2 of the protected region size

  // Code n protects 2^(ADDR_W-7+n) bytes; zero protects nothing, all-ones protects everything
  always_comb begin
    lowBits = ADDR_W - awpc_pkg::FRACTION_SHIFT + int'(code);
    lowMask = ~({ADDR_W{1'b1}} << lowBits);
    if (code == 3'h0) begin
      // No protection
      hit = 1'b0;
    end else if (code == 3'h7) begin
      // Whole array
      hit = 1'b1;
    end else if (fromBottom) begin
      // Bottom anchored: upper bits all zero
      hit = ~|(addr & ~lowMask);
    end else begin
      // Top anchored: upper bits all one
      hit = &(addr | lowMask);
    end
  end

endmodule

// *** tb_top.sv ***
// Self-checking bench for the array write protection controller
`timescale 1ns/10ps
module tb_top;
  // ****************************************
  // Stimulus and observation
  // ****************************************
  logic                 clk = 1'b0;           // 10 MHz clock
  logic                 rst = 1'b1;           // Async reset
  logic                 writeProtectN = 1'b1; // Protect pin, idle high
  logic [2:0]           hwBlockProtectPins = 3'h0; // Pins default low
  logic                 hwRangeEndSelect = 1'b0;   // Top anchored
  logic                 busy = 1'b0;          // Array engine state
  logic                 chipSelectN;          // From host model
  awpc_pkg::awpc_req_s  req;                  // From host model
  awpc_pkg::awpc_resp_s resp;                 // From design
  awpc_pkg::awpc_resp_s r;                    // Last answer
  int                   n_errors = 0;         // Mismatches
  int                   tests_run = 0;        // Comparisons
  int                   cycles = 0;           // Hang guard
  integer               seed = 32'h1d7a;      // Fixed seed
  logic [7:0]           sr = 8'h00;           // Expected status, latch bit kept 0
  logic [7:0]           cr = 8'h60;           // Expected config one
  logic                 latch = 1'b0;         // Expected latch
  logic                 regDone = 1'b0;       // Granted reg write this frame
  logic [23:0]          sz;                   // Region size scratch
  logic [23:0]          a;                    // Address scratch

  always #50 clk = ~clk;

  awpc_ctrl u_awpc_ctrl (.clk(clk), .rst(rst), .chipSelectN(chipSelectN),
    .writeProtectN(writeProtectN), .hwBlockProtectPins(hwBlockProtectPins),
    .hwRangeEndSelect(hwRangeEndSelect), .busy(busy), .req(req), .resp(resp));

  awpc_host_model u_awpc_host_model (.clk(clk), .resp(resp), .req(req),
    .chipSelectN(chipSelectN));

  // ****************************************
  // Expectations and checks
  // ****************************************
  // Whether a code protects an address; 7 covers all, 0 none
  function automatic logic inRange(input logic [2:0] c, input logic b, input logic [23:0] ad);
    logic [23:0] s;
    s = 24'h1 << (16 + c);
    if (c == 3'h0) return 1'b0;
    if (c == 3'h7) return 1'b1;
    return b ? (ad[22:0] < s) : ({1'b0, ad[22:0]} >= 24'h800000 - s);
  endfunction

  task automatic checkOk(input logic got, input logic exp);
    tests_run++;
    if (got !== exp) begin
      n_errors++;
      $display("MISMATCH %0t grant got %b expected %b", $time, got, exp);
    end
  endtask

  task automatic checkData(input logic [31:0] got, input logic [31:0] exp);
    tests_run++;
    if (got !== exp) begin
      n_errors++;
      $display("MISMATCH %0t data got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic rq(input awpc_pkg::awpc_kind_e k, input logic [7:0] ra,
                    input logic [7:0] d, input logic [23:0] ad);
    u_awpc_host_model.request(k, ra, d, ad, r);
  endtask

  // Register read compared in full, unmapped reads answer zero
  task automatic rd(input logic [7:0] ra, input logic [31:0] exp, input logic okExp);
    rq(awpc_pkg::REQ_REG_READ, ra, 8'h00, 24'h0);
    checkOk(r.ok, okExp);
    checkData(r.data, exp);
  endtask

  // Status read shows the live latch in bit 1
  task automatic rdStatus();
    rd(awpc_pkg::OFS_STATUS, {24'h0, sr[7:2], latch, sr[0]}, 1'b1);
  endtask

  // Register write; lock keeps range bits, others still land
  task automatic wrReg(input logic [7:0] ra, input logic [7:0] d);
    logic ok;
    logic [7:0] keep;
    ok = latch && !(sr[7] && !writeProtectN);
    keep = cr[2] ? awpc_pkg::SR_LOCKED_MSK : 8'h00;
    rq(awpc_pkg::REQ_REG_WRITE, ra, d, 24'h0);
    checkOk(r.ok, ok);
    if (ok && ra == awpc_pkg::OFS_STATUS) sr = (d & 8'hfd & ~keep) | (sr & keep);
    if (ok && ra == awpc_pkg::OFS_CONFIG1) cr = d & awpc_pkg::CR_WR_MSK;
    if (ok) regDone = 1'b1;
  endtask

  task automatic setLatch();
    rq(awpc_pkg::REQ_SET_LATCH, 8'h00, 8'h00, 24'h0);
    latch = 1'b1;
  endtask

  // Array write: refused in either range, else needs latch unless mode 01
  task automatic arr(input logic [23:0] ad);
    logic exp;
    exp = !(inRange(sr[4:2], sr[5], ad) || inRange(hwBlockProtectPins, hwRangeEndSelect, ad))
          && (latch || cr[1:0] == awpc_pkg::MODE_SRAM);
    rq(awpc_pkg::REQ_ARRAY_WRITE, 8'h00, 8'h00, ad);
    checkOk(r.ok, exp);
  endtask

  // Frame end clears the latch except in mode 10 without a reg write
  task automatic frameEnd();
    u_awpc_host_model.frameClose();
    if (!(cr[1:0] == awpc_pkg::MODE_B2B && !regDone)) latch = 1'b0;
    regDone = 1'b0;
    u_awpc_host_model.frameOpen();
  endtask

  // Pins cross a synchroniser, so let them settle
  task automatic settle();
    repeat (6) @(posedge clk);
    #1;
  endtask

  task automatic complete_run();
    if (n_errors == 0 && tests_run > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask

  // Hang guard, well above the expected run length
  always @(posedge clk) begin
    cycles++;
    if (cycles == 30000) begin
      n_errors++;
      complete_run();
    end
  end

  // ****************************************
  // Main sequence
  // ****************************************
  initial begin
    repeat (12) @(posedge clk);
    #1;
    rst = 1'b0;
    u_awpc_host_model.frameOpen();
    // Reset values and read-only words
    rdStatus();
    rd(awpc_pkg::OFS_CONFIG1, 32'h60, 1'b1);
    rd(awpc_pkg::OFS_FLAGS, 32'h80, 1'b1);
    rd(awpc_pkg::OFS_IDENT, 32'h3c212101, 1'b1);
    rd(8'h05, 32'h0, 1'b0);
    // Register gating by latch, pin enable and pin
    wrReg(awpc_pkg::OFS_STATUS, 8'h9c);
    setLatch();
    rdStatus();
    wrReg(awpc_pkg::OFS_STATUS, 8'h80);
    writeProtectN = 1'b0;
    settle();
    wrReg(awpc_pkg::OFS_STATUS, 8'h00);
    writeProtectN = 1'b1;
    settle();
    wrReg(awpc_pkg::OFS_STATUS, 8'h00);
    frameEnd();
    wrReg(awpc_pkg::OFS_STATUS, 8'h04);
    // Random ranges, pins and addresses with boundary corners
    repeat (40) begin
      busy = 1'($random(seed));
      writeProtectN = 1'($random(seed));
      hwBlockProtectPins = 3'($random(seed));
      hwRangeEndSelect = 1'($random(seed));
      settle();
      setLatch();
      wrReg(awpc_pkg::OFS_STATUS, 8'($random(seed)));
      rd(awpc_pkg::OFS_FLAGS, {24'h0, ~busy, 7'h0}, 1'b1);
      sz = 24'h1 << (16 + sr[4:2]);
      a = sr[5] ? sz : 24'h800000 - sz;
      arr(24'($random(seed)) & 24'h7fffff);
      arr(a);
      arr(a - 24'h1);
      arr(sr[5] ? 24'h0 : 24'h7fffff);
      frameEnd();
      arr(24'($random(seed)) & 24'h7fffff);
    end
    // Write enable modes on an unprotected array
    hwBlockProtectPins = 3'h0;
    writeProtectN = 1'b1;
    settle();
    setLatch();
    wrReg(awpc_pkg::OFS_STATUS, 8'h00);
    wrReg(awpc_pkg::OFS_CONFIG1, 8'h61);
    frameEnd();
    arr(24'h123456);
    setLatch();
    wrReg(awpc_pkg::OFS_CONFIG1, 8'h62);
    frameEnd();
    setLatch();
    arr(24'h000100);
    frameEnd();
    arr(24'h7fff00);
    rq(awpc_pkg::REQ_CLR_LATCH, 8'h00, 8'h00, 24'h0);
    latch = 1'b0;
    arr(24'h7fff00);
    setLatch();
    wrReg(awpc_pkg::OFS_CONFIG1, 8'h60);
    frameEnd();
    setLatch();
    arr(24'h2a0000);
    frameEnd();
    arr(24'h2a0000);
    // Lock freezes range bits only, then unlock
    setLatch();
    wrReg(awpc_pkg::OFS_CONFIG1, 8'h64);
    wrReg(awpc_pkg::OFS_STATUS, 8'h7d);
    rdStatus();
    wrReg(awpc_pkg::OFS_CONFIG1, 8'h60);
    wrReg(awpc_pkg::OFS_STATUS, 8'h3c);
    rdStatus();
    complete_run();
  end
endmodule
